// ---- include/rsc_pkg.sv ----
// Constants for the reset source controller.
package rsc_pkg;
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned CLK_NS       = 100;
    localparam int unsigned SETTLE_MS    = 40;
    localparam int unsigned SETTLE_CYC   = SETTLE_MS * (CLK_HZ / 1000);
    localparam int unsigned PIN_MIN_NS   = 200;
    localparam int unsigned PIN_MIN_CYC  = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned EXT_CYC      = 1024;
    localparam int unsigned LV_QUAL_CYC  = 1024;
    localparam int unsigned CNT_W        = 20;
    localparam logic [1:0]  PIN_ACCEPT   = 2'(PIN_MIN_CYC + 1);
    localparam logic [9:0]  LV_CNT_LAST  = 10'(LV_QUAL_CYC - 1);
    localparam logic [2:0]  WD_DIV_LAST  = 3'h7;
    localparam logic [7:0]  WD_LIMIT_BASE = 8'h1f;
    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0]  IDX_FLAGS    = 8'h30;
    localparam logic [7:0]  IDX_LVSEL    = 8'h36;
    localparam logic [7:0]  IDX_WDCLR    = 8'h37;
    localparam logic [7:0]  IDX_MODE     = 8'h38;
    localparam logic [7:0]  IDX_OPTION   = 8'h39;
    localparam logic [7:0]  FLAGS_RESET  = 8'h80;
    localparam logic [7:0]  FLAGS_MASK   = 8'hec;
    localparam logic [7:0]  OPTION_RESET = 8'h00;
    localparam logic [7:0]  WD_CLEAR_KEY = 8'h55;
    localparam logic [7:0]  SOFT_RST_KEY = 8'h66;
    localparam int unsigned F_POR        = 7;
    localparam int unsigned F_PIN        = 6;
    localparam int unsigned F_LV         = 5;
    localparam int unsigned F_WD         = 3;
    localparam int unsigned F_IA         = 2;
    localparam int unsigned OPT_WD_EN    = 0;
    localparam int unsigned OPT_LV_EN    = 2;
    localparam int unsigned OPT_WD_SEL   = 3;
    localparam int unsigned OPT_PORT_INIT = 5;
    localparam logic [15:0] WORK_LO      = 16'h0000;
    localparam logic [15:0] WORK_HI      = 16'h00bf;
    localparam logic [15:0] STACK_LO     = 16'h0100;
    localparam logic [15:0] STACK_HI     = 16'h01ff;
    localparam logic [15:0] ROM_LO       = 16'hf000;
    localparam logic [15:0] ROM_HI       = 16'hffff;
    typedef enum logic [7:0] {
        RSC_RUN        = 8'h01,
        RSC_POR_PWR    = 8'h02,
        RSC_POR_CLK    = 8'h04,
        RSC_PIN_LOW    = 8'h08,
        RSC_PIN_SETTLE = 8'h10,
        RSC_PIN_TAIL   = 8'h20,
        RSC_LV_LOW     = 8'h40,
        RSC_LV_EXT     = 8'h80
    } rsc_state_e;
endpackage

// ---- core/rsc_top.sv ----
// Reset source controller: sources, stretching, cause flags and bus registers.
// Functional notes
// - Power-on: hold reset 40ms for power, then 40ms more for clock.
// - Power-on reset loads flags with 0x80, clears level select and resets CPU and peripherals.
// - Pin reset is active low; lows of 200ns or less are ignored.
// - Accepted pin reset is stretched by 40ms plus 1024 clocks.
// - Low-voltage reset works only when the option byte enables it.
// - Low-voltage trips after 1024 consecutive clocks below the level.
// - Low-voltage reset is held 1024 clocks after the supply recovers.
// - Level select bit 0: 0 picks 2.5V, 1 picks 4.0V.
// - Low-voltage events are ignored during power-on or pin reset periods.
// - In STOP mode low-voltage is off; a supply drop gives power-on reset.
// - Watchdog time-out resets only the CPU, not peripherals.
// - Watchdog time base is the watchdog oscillator divided by eight.
// - Writing 0x55 clears the watchdog; a time-out restarts it, flag kept.
// - Fetch outside work and stack, or ROM write, resets only the CPU.
// - Writing 0x66 to mode control resets peripherals only.
// - Source-to-region map; port attributes follow option on peripheral resets.
// - Cause flags: bit7 power-on, 6 pin, 5 low-voltage, 3 watchdog, 2 address.
// - A cause flag clears when software writes one to it, or on power-on reset.
// - Flags and level select take a write only when written twice.
// - Pin and low-voltage resets set only their own cause flag.
// - Level select is settable once and cleared only by power-on.
module rsc_top #(
    parameter int unsigned SETTLE_CYC = rsc_pkg::SETTLE_CYC
) (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        EXT_RESET_N,
    input  wire logic        SUPPLY_BELOW_2V5,
    input  wire logic        SUPPLY_BELOW_4V0,
    input  wire logic        WDT_OSC_TICK,
    input  wire logic        STOP_MODE,
    input  wire logic        CPU_FETCH,
    input  wire logic        CPU_WRITE,
    input  wire logic [15:0] CPU_ADDR,
    output logic             CPU_RESET,
    output logic             PERIPH_RESET,
    output logic             PORT_ATTR_RESET,
    output logic             LOW_VOLTAGE_LEVEL_HIGH
);
    rsc_pkg::rsc_state_e state_r, state_nxt;
    logic [rsc_pkg::CNT_W-1:0] cnt_r;
    logic [1:0] pin_sync_r, lo25_sync_r, lo40_sync_r, wd_sync_r;
    logic       wd_tick_d_r;
    logic [1:0] pin_cnt_r;
    logic [9:0] lv_cnt_r;
    logic [2:0] wd_pre_r;
    logic [7:0] wd_cnt_r;
    logic [7:0] flags_r, option_r;
    logic       lv_sel_r;
    logic       pend_v_r;
    logic [7:0] pend_idx_r, pend_data_r;
    logic       ack_r;
    logic       cpu_rst_r, periph_rst_r, port_rst_r;
    logic [31:0] rdata_r;

    logic pin_low, supply_low, pin_ok, por_trig, lv_armed, lv_trig, done;
    logic wdr_evt, iar_evt, soft_evt, wd_clear, wd_tick;
    logic [7:0] idx, wdata, set_bits, wd_limit;
    logic wr_take, acc_take, dbl_reg, commit, commit_flags, commit_lvsel;
    logic in_work, in_stack, in_rom, holding;

    // External and analog levels pass two flops; bit 1 is the first stage.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_sync_r  <= 2'h0;
            lo25_sync_r <= 2'h0;
            lo40_sync_r <= 2'h0;
            wd_sync_r   <= 2'h0;
        end else begin
            pin_sync_r  <= {~EXT_RESET_N, pin_sync_r[1]};
            lo25_sync_r <= {SUPPLY_BELOW_2V5, lo25_sync_r[1]};
            lo40_sync_r <= {SUPPLY_BELOW_4V0, lo40_sync_r[1]};
            wd_sync_r   <= {WDT_OSC_TICK, wd_sync_r[1]};
        end
    end

    assign pin_low    = pin_sync_r[0];
    assign supply_low = lv_sel_r ? lo40_sync_r[0] : lo25_sync_r[0];

    // Low pulses must outlast the filter before the pin counts as a reset.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_cnt_r <= 2'h0;
        end else if (!pin_low) begin
            pin_cnt_r <= 2'h0;
        end else if (pin_cnt_r != rsc_pkg::PIN_ACCEPT) begin
            pin_cnt_r <= pin_cnt_r + 2'h1;
        end
    end
    assign pin_ok = pin_cnt_r == rsc_pkg::PIN_ACCEPT;

    assign por_trig = STOP_MODE && supply_low;
    assign lv_armed = option_r[rsc_pkg::OPT_LV_EN] && !STOP_MODE
                      && state_r == rsc_pkg::RSC_RUN;
    assign lv_trig  = lv_armed && supply_low && lv_cnt_r == rsc_pkg::LV_CNT_LAST;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            lv_cnt_r <= 10'h000;
        end else if (!lv_armed || !supply_low) begin
            lv_cnt_r <= 10'h000;
        end else if (lv_cnt_r != rsc_pkg::LV_CNT_LAST) begin
            lv_cnt_r <= lv_cnt_r + 10'h001;
        end
    end

    always_comb begin
        done = 1'b0;
        unique case (state_r)
            rsc_pkg::RSC_POR_PWR, rsc_pkg::RSC_POR_CLK, rsc_pkg::RSC_PIN_SETTLE: begin
                done = cnt_r == rsc_pkg::CNT_W'(SETTLE_CYC - 1);
            end
            rsc_pkg::RSC_PIN_TAIL, rsc_pkg::RSC_LV_EXT: begin
                done = cnt_r == rsc_pkg::CNT_W'(rsc_pkg::EXT_CYC - 1);
            end
            default: begin
                done = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rsc_pkg::RSC_RUN: begin
                if (pin_ok) begin
                    state_nxt = rsc_pkg::RSC_PIN_LOW;
                end else if (lv_trig) begin
                    state_nxt = rsc_pkg::RSC_LV_LOW;
                end
            end
            rsc_pkg::RSC_POR_PWR: begin
                if (done) begin
                    state_nxt = rsc_pkg::RSC_POR_CLK;
                end
            end
            rsc_pkg::RSC_POR_CLK: begin
                if (done) begin
                    state_nxt = rsc_pkg::RSC_RUN;
                end
            end
            rsc_pkg::RSC_PIN_LOW: begin
                if (!pin_low) begin
                    state_nxt = rsc_pkg::RSC_PIN_SETTLE;
                end
            end
            rsc_pkg::RSC_PIN_SETTLE, rsc_pkg::RSC_PIN_TAIL: begin
                if (pin_ok) begin
                    state_nxt = rsc_pkg::RSC_PIN_LOW;
                end else if (done) begin
                    state_nxt = state_r == rsc_pkg::RSC_PIN_SETTLE
                              ? rsc_pkg::RSC_PIN_TAIL : rsc_pkg::RSC_RUN;
                end
            end
            rsc_pkg::RSC_LV_LOW: begin
                if (pin_ok) begin
                    state_nxt = rsc_pkg::RSC_PIN_LOW;
                end else if (!supply_low) begin
                    state_nxt = rsc_pkg::RSC_LV_EXT;
                end
            end
            rsc_pkg::RSC_LV_EXT: begin
                if (pin_ok) begin
                    state_nxt = rsc_pkg::RSC_PIN_LOW;
                end else if (supply_low) begin
                    state_nxt = rsc_pkg::RSC_LV_LOW;
                end else if (done) begin
                    state_nxt = rsc_pkg::RSC_RUN;
                end
            end
            default: begin
                state_nxt = rsc_pkg::RSC_POR_PWR;
            end
        endcase
        if (por_trig) begin
            state_nxt = rsc_pkg::RSC_POR_PWR;
        end
    end

    // Reset release starts the power-on sequence.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_r <= rsc_pkg::RSC_POR_PWR;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
        end
    end

    // Watchdog: oscillator ticks divided by eight feed the time-out counter.
    assign wd_tick  = wd_sync_r[0] && !wd_tick_d_r;
    assign wd_limit = rsc_pkg::WD_LIMIT_BASE << option_r[rsc_pkg::OPT_WD_SEL +: 2];
    assign wdr_evt  = option_r[rsc_pkg::OPT_WD_EN] && wd_tick
                      && wd_pre_r == rsc_pkg::WD_DIV_LAST && wd_cnt_r == wd_limit;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            wd_tick_d_r <= 1'b0;
            wd_pre_r    <= 3'h0;
            wd_cnt_r    <= 8'h00;
        end else begin
            wd_tick_d_r <= wd_sync_r[0];
            if (wd_clear || wdr_evt || !option_r[rsc_pkg::OPT_WD_EN]) begin
                wd_pre_r <= 3'h0;
                wd_cnt_r <= 8'h00;
            end else if (wd_tick) begin
                wd_pre_r <= wd_pre_r + 3'h1;
                if (wd_pre_r == rsc_pkg::WD_DIV_LAST) begin
                    wd_cnt_r <= wd_cnt_r + 8'h01;
                end
            end
        end
    end

    assign in_work  = CPU_ADDR >= rsc_pkg::WORK_LO && CPU_ADDR <= rsc_pkg::WORK_HI;
    assign in_stack = CPU_ADDR >= rsc_pkg::STACK_LO && CPU_ADDR <= rsc_pkg::STACK_HI;
    assign in_rom   = CPU_ADDR >= rsc_pkg::ROM_LO && CPU_ADDR <= rsc_pkg::ROM_HI;
    assign iar_evt  = (CPU_FETCH && !in_work && !in_stack)
                      || (CPU_WRITE && in_rom);

    // Bus slave: one wait cycle, the request is taken on the second edge.
    assign idx      = AVS_ADDRESS[9:2];
    assign wdata    = AVS_WRITEDATA[7:0];
    assign acc_take = (AVS_READ || AVS_WRITE) && ack_r;
    assign wr_take  = AVS_WRITE && ack_r && AVS_BYTEENABLE[0];
    assign dbl_reg  = idx == rsc_pkg::IDX_FLAGS || idx == rsc_pkg::IDX_LVSEL;
    assign commit   = wr_take && dbl_reg && pend_v_r && pend_idx_r == idx
                      && pend_data_r == wdata;
    assign commit_flags = commit && idx == rsc_pkg::IDX_FLAGS;
    assign commit_lvsel = commit && idx == rsc_pkg::IDX_LVSEL;
    assign wd_clear = wr_take && idx == rsc_pkg::IDX_WDCLR
                      && wdata == rsc_pkg::WD_CLEAR_KEY;
    assign soft_evt = wr_take && idx == rsc_pkg::IDX_MODE
                      && wdata == rsc_pkg::SOFT_RST_KEY;
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;
    assign AVS_READDATA    = rdata_r;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
        end
    end

    // Any other access between the two halves breaks a double write.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pend_v_r    <= 1'b0;
            pend_idx_r  <= 8'h00;
            pend_data_r <= 8'h00;
        end else if (acc_take) begin
            pend_v_r    <= wr_take && dbl_reg && !commit;
            pend_idx_r  <= idx;
            pend_data_r <= wdata;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            rdata_r <= 32'h0000_0000;
        end else if (AVS_READ && !ack_r) begin
            unique case (idx)
                rsc_pkg::IDX_FLAGS:  rdata_r <= {24'h000000, flags_r};
                rsc_pkg::IDX_LVSEL:  rdata_r <= {31'h00000000, lv_sel_r};
                rsc_pkg::IDX_OPTION: rdata_r <= {24'h000000, option_r};
                default:             rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Cause flags: a new event wins over a clear in the same cycle.
    always_comb begin
        set_bits = 8'h00;
        set_bits[rsc_pkg::F_POR] = por_trig;
        set_bits[rsc_pkg::F_PIN] = state_nxt == rsc_pkg::RSC_PIN_LOW
                                   && state_r != rsc_pkg::RSC_PIN_LOW;
        set_bits[rsc_pkg::F_LV]  = lv_trig;
        set_bits[rsc_pkg::F_WD]  = wdr_evt;
        set_bits[rsc_pkg::F_IA]  = iar_evt;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            flags_r <= rsc_pkg::FLAGS_RESET;
        end else if (por_trig) begin
            flags_r <= rsc_pkg::FLAGS_RESET | set_bits;
        end else if (commit_flags) begin
            flags_r <= (flags_r & ~(wdata & rsc_pkg::FLAGS_MASK)) | set_bits;
        end else begin
            flags_r <= flags_r | set_bits;
        end
    end

    // The level select only ever goes from 0 to 1 until power-on.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            lv_sel_r <= 1'b0;
        end else if (por_trig) begin
            lv_sel_r <= 1'b0;
        end else if (commit_lvsel) begin
            lv_sel_r <= lv_sel_r | wdata[0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            option_r <= rsc_pkg::OPTION_RESET;
        end else if (wr_take && idx == rsc_pkg::IDX_OPTION) begin
            option_r <= wdata;
        end
    end

    assign holding = state_r != rsc_pkg::RSC_RUN;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cpu_rst_r    <= 1'b1;
            periph_rst_r <= 1'b1;
            port_rst_r   <= 1'b1;
        end else begin
            cpu_rst_r    <= holding || wdr_evt || iar_evt;
            periph_rst_r <= holding || soft_evt;
            port_rst_r   <= (holding || soft_evt)
                            && option_r[rsc_pkg::OPT_PORT_INIT];
        end
    end
    assign CPU_RESET              = cpu_rst_r;
    assign PERIPH_RESET           = periph_rst_r;
    assign PORT_ATTR_RESET        = port_rst_r;
    assign LOW_VOLTAGE_LEVEL_HIGH = lv_sel_r;

    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);

    hold_resets_a: assert property (holding |=> CPU_RESET && PERIPH_RESET)
        else $error("Resets not held during a reset period.");
    por_phase_a: assert property (state_r == rsc_pkg::RSC_POR_PWR
        && state_nxt == rsc_pkg::RSC_POR_CLK |-> done)
        else $error("Power settle ended early.");
    pin_filter_a: assert property (state_r == rsc_pkg::RSC_RUN
        && state_nxt == rsc_pkg::RSC_PIN_LOW |-> $past(pin_low) && pin_low)
        else $error("Short pin pulse accepted.");
    pin_tail_a: assert property (state_r == rsc_pkg::RSC_PIN_TAIL
        && state_nxt == rsc_pkg::RSC_RUN |-> done && !por_trig)
        else $error("Pin reset tail cut short.");
    lv_enable_a: assert property (!option_r[rsc_pkg::OPT_LV_EN] || STOP_MODE
        |-> !lv_trig)
        else $error("Low-voltage reset while disabled.");
    lv_qual_a: assert property (lv_trig |-> $past(supply_low) && $past(lv_armed))
        else $error("Low-voltage trip without qualification.");
    lv_ignore_a: assert property (state_r inside {rsc_pkg::RSC_POR_PWR,
        rsc_pkg::RSC_POR_CLK, rsc_pkg::RSC_PIN_LOW} |-> !lv_trig)
        else $error("Low-voltage event not ignored.");
    wd_cpu_only_a: assert property (wdr_evt && !holding && !soft_evt
        && state_nxt == rsc_pkg::RSC_RUN |=> CPU_RESET && !PERIPH_RESET)
        else $error("Watchdog reset reached peripherals.");
    wd_flag_a: assert property (wdr_evt |=> flags_r[rsc_pkg::F_WD] && wd_cnt_r == 8'h00)
        else $error("Watchdog flag or counter wrong.");
    soft_only_a: assert property (soft_evt && !holding && !wdr_evt && !iar_evt
        && state_nxt == rsc_pkg::RSC_RUN |=> PERIPH_RESET && !CPU_RESET)
        else $error("Software reset touched the CPU.");
    single_write_a: assert property (!commit_lvsel && !por_trig |=> $stable(lv_sel_r))
        else $error("Level select changed without a double write.");
    level_once_a: assert property (lv_sel_r && !por_trig |=> lv_sel_r)
        else $error("Level select cleared.");

    por_done_c: cover property (state_r == rsc_pkg::RSC_POR_CLK
        && state_nxt == rsc_pkg::RSC_RUN);
    pin_reset_c: cover property (state_r == rsc_pkg::RSC_PIN_TAIL
        && state_nxt == rsc_pkg::RSC_RUN);
    lv_reset_c: cover property (state_r == rsc_pkg::RSC_LV_EXT
        && state_nxt == rsc_pkg::RSC_RUN);
    dbl_write_c: cover property (commit_flags);
endmodule

// ---- verification/rsc_far.sv ----
// Far-side model: reset pin with pull-up, supply detectors, watchdog oscillator.
module rsc_far #(
    parameter int unsigned HALF = 2
) (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [31:0] len,
    input  wire logic [31:0] mv,
    output logic             pin_n,
    output logic             lo25,
    output logic             lo40,
    output logic             tick
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned left = 0;
    int unsigned div = 0;
    initial begin
        pin_n = 1'b1;
        lo25 = 1'b0;
        lo40 = 1'b0;
        tick = 1'b0;
    end
    // The pin idles high through its pull-up and is held low for len cycles.
    always @(posedge clk) begin
        left <= go ? len : (left != 0 ? left - 1 : 0);
        pin_n <= !(go || left > 1);
        lo25 <= mv < 2500;
        lo40 <= mv < 4000;
        div <= (div == HALF - 1) ? 0 : div + 1;
        if (div == HALF - 1) begin
            tick <= !tick;
        end
    end
endmodule

// ---- verification/reset_source_controller_tb.sv ----
// Self-checking testbench for the reset source controller.
module reset_source_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SC = 50;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic [9:0]  AVS_ADDRESS = 10'h000;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic        EXT_RESET_N;
    logic        LO25;
    logic        LO40;
    logic        TICK;
    logic        STOP_MODE = 1'b0;
    logic        CPU_FETCH = 1'b0;
    logic        CPU_WRITE = 1'b0;
    logic [15:0] CPU_ADDR = 16'h0000;
    logic        CPU_RESET;
    logic        PERIPH_RESET;
    logic        PORT_ATTR_RESET;
    logic        LVH;
    logic        go = 1'b0;
    int unsigned len = 0;
    int unsigned mv = 5000;
    int          miscompares = 0;
    int          comparisons = 0;
    logic        cs = 1'b0;
    logic        ps = 1'b0;
    logic        as = 1'b0;
    logic [7:0]  q;
    int          n;

    rsc_top #(.SETTLE_CYC(SC)) i_dut (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'h1),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXT_RESET_N(EXT_RESET_N),
        .SUPPLY_BELOW_2V5(LO25), .SUPPLY_BELOW_4V0(LO40), .WDT_OSC_TICK(TICK),
        .STOP_MODE(STOP_MODE), .CPU_FETCH(CPU_FETCH), .CPU_WRITE(CPU_WRITE),
        .CPU_ADDR(CPU_ADDR), .CPU_RESET(CPU_RESET), .PERIPH_RESET(PERIPH_RESET),
        .PORT_ATTR_RESET(PORT_ATTR_RESET), .LOW_VOLTAGE_LEVEL_HIGH(LVH));
    rsc_far i_far (.clk(MCLK), .go(go), .len(len), .mv(mv), .pin_n(EXT_RESET_N),
        .lo25(LO25), .lo40(LO40), .tick(TICK));

    initial begin
        forever #50 MCLK = ~MCLK;
    end
    always @(negedge MCLK) begin
        cs = cs | (CPU_RESET === 1'b1);
        ps = ps | (PERIPH_RESET === 1'b1);
        as = as | (PORT_ATTR_RESET === 1'b1);
    end

    task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge MCLK);
        AVS_ADDRESS <= {idx, 2'h0};
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= {24'h000000, d};
        do begin
            @(posedge MCLK);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 100);
        if (AVS_WAITREQUEST !== 1'b0) begin
            miscompares++;
        end
        q = AVS_READDATA[7:0];
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic rd(input string w, input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        check(w, q, e);
    endtask
    task automatic wr2(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        bus(1'b1, idx, d);
    endtask
    task automatic waitc(input logic lvl, input int max);
        n = 0;
        do begin
            @(negedge MCLK);
            n++;
        end while (CPU_RESET !== lvl && n < max);
    endtask
    task automatic set_mv(input int unsigned v);
        @(posedge MCLK);
        mv <= v;
    endtask
    task automatic pin(input int unsigned l);
        @(posedge MCLK);
        go <= 1'b1;
        len <= l;
        @(posedge MCLK);
        go <= 1'b0;
    endtask

    task automatic t_por();
        waitc(1'b0, 300);
        check("por time", n >= 2 * SC && n <= 2 * SC + 3, 1);
        check("por periph", PERIPH_RESET, 0);
        rd("flags", 8'h30, 8'h80);
        rd("lvsel", 8'h36, 8'h00);
        rd("unmapped", 8'h10, 8'h00);
    endtask
    task automatic t_dw();
        wr2(8'h30, 8'h00);
        rd("flags w0", 8'h30, 8'h80);
        bus(1'b1, 8'h30, 8'hff);
        rd("flags single", 8'h30, 8'h80);
        bus(1'b1, 8'h30, 8'hff);
        bus(1'b1, 8'h30, 8'h7f);
        rd("flags unequal", 8'h30, 8'h80);
        wr2(8'h30, 8'hff);
        rd("flags w1c", 8'h30, 8'h00);
        bus(1'b1, 8'h36, 8'h01);
        rd("lvsel single", 8'h36, 8'h00);
        wr2(8'h36, 8'h01);
        @(negedge MCLK);
        check("level high", LVH, 1);
        wr2(8'h36, 8'h00);
        rd("lvsel sticky", 8'h36, 8'h01);
    endtask
    task automatic t_lv();
        cs = 1'b0;
        set_mv(3000);
        repeat (1100) @(negedge MCLK);
        check("lv off", cs, 0);
        set_mv(5000);
        bus(1'b1, 8'h39, 8'h04);
        repeat (5) @(negedge MCLK);
        set_mv(3000);
        waitc(1'b1, 1100);
        check("lv trip", n >= 1024 && n <= 1034, 1);
        check("lv periph", PERIPH_RESET, 1);
        set_mv(5000);
        waitc(1'b0, 1100);
        check("lv hold", n >= 1024 && n <= 1034, 1);
        rd("lv flag", 8'h30, 8'h20);
        wr2(8'h30, 8'hff);
    endtask
    task automatic t_pin();
        cs = 1'b0;
        pin(2);
        repeat (20) @(negedge MCLK);
        check("short pin", cs, 0);
        pin(6);
        set_mv(3000);
        repeat (1060) @(negedge MCLK);
        check("pin periph", ps, 1);
        set_mv(5000);
        waitc(1'b0, 200);
        check("pin time", n + 1062 >= 1075 && n + 1062 <= 1092, 1);
        rd("pin flag", 8'h30, 8'h40);
        check("pin level kept", LVH, 1);
        wr2(8'h30, 8'hff);
    endtask
    task automatic t_wd();
        bus(1'b1, 8'h39, 8'h05);
        repeat (800) @(negedge MCLK);
        bus(1'b1, 8'h37, 8'h55);
        ps = 1'b0;
        waitc(1'b1, 1200);
        check("wd time", n >= 960 && n <= 1060, 1);
        repeat (3) @(negedge MCLK);
        check("wd periph", ps, 0);
        bus(1'b1, 8'h39, 8'h04);
        rd("wd flag", 8'h30, 8'h08);
        wr2(8'h30, 8'hff);
    endtask
    task automatic t_ia();
        logic [15:0] a[4] = '{16'h0200, 16'h01ff, 16'hf000, 16'h00c0};
        logic        f[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic        e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            cs = 1'b0;
            ps = 1'b0;
            @(posedge MCLK);
            CPU_ADDR <= a[i];
            CPU_FETCH <= f[i];
            CPU_WRITE <= !f[i];
            @(posedge MCLK);
            CPU_FETCH <= 1'b0;
            CPU_WRITE <= 1'b0;
            repeat (4) @(negedge MCLK);
            check("ia cpu", cs, e[i]);
            check("ia periph", ps, 0);
        end
        rd("ia flag", 8'h30, 8'h04);
        wr2(8'h30, 8'hff);
    endtask
    task automatic t_sw();
        ps = 1'b0;
        bus(1'b1, 8'h38, 8'h65);
        repeat (3) @(negedge MCLK);
        check("sw wrong key", ps, 0);
        cs = 1'b0;
        as = 1'b0;
        bus(1'b1, 8'h38, 8'h66);
        repeat (3) @(negedge MCLK);
        check("sw periph", ps, 1);
        check("sw cpu", cs, 0);
        check("sw attr off", as, 0);
        bus(1'b1, 8'h39, 8'h24);
        bus(1'b1, 8'h38, 8'h66);
        repeat (3) @(negedge MCLK);
        check("sw attr on", as, 1);
    endtask
    task automatic t_stop();
        @(posedge MCLK);
        STOP_MODE <= 1'b1;
        set_mv(2000);
        waitc(1'b1, 50);
        check("stop reset", CPU_RESET, 1);
        check("stop level", LVH, 0);
        set_mv(5000);
        STOP_MODE <= 1'b0;
        waitc(1'b0, 400);
        rd("stop flags", 8'h30, 8'h80);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (comparisons > 0 && miscompares == 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (15000) @(posedge MCLK);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge MCLK);
        RST <= 1'b0;
        t_por();
        t_dw();
        t_lv();
        t_pin();
        t_wd();
        t_ia();
        t_sw();
        t_stop();
        end_of_test();
    end
endmodule
